//--- verilog/cihr_pkg.sv
`default_nettype none
package cihr_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 8;
  localparam logic [15:0] RESET_PC       = 16'h0000;
  localparam logic [15:0] NMI_PC         = 16'h0066;
  localparam logic [7:0]  REFRESH_INIT   = 8'h00;
  localparam logic [2:0]  MC_FIRST_PUSH  = 3'h1;
  localparam logic [2:0]  MC_LAST_PUSH   = 3'h2;
  localparam logic [2:0]  MC_TABLE_LO    = 3'h3;
  localparam logic [2:0]  MC_LAST_INT    = 3'h4;
  localparam logic [2:0]  MC_LAST_NMI    = 3'h2;
  localparam int          RESET_MIN_CLKS = 3;
  localparam int          NMI_LOW_CLKS   = 2;
  typedef enum logic [1:0] {CYC_NORMAL, CYC_INT, CYC_NMI} cihr_entry_t;
endpackage : cihr_pkg
`default_nettype wire

//--- verilog/cihr_bus_if.sv
`default_nettype none
interface cihr_bus_if;
  logic [15:0] addr;
  logic        addr_oe;
  logic [7:0]  cpu_data;
  logic        cpu_data_oe;
  logic [7:0]  sys_data;
  logic        sys_data_oe;
  logic        ctrl_oe;
  logic        memory_request_n;
  logic        io_request_n;
  logic        read_n;
  logic        write_n;
  logic        halt_n;
  logic        first_cycle_n;
  logic        refresh_strobe_n;
  logic        wait_n;
  logic        maskable_irq_n;
  logic        nonmask_irq_n;
  logic        bus_request_n;
  logic        reset_n;
  logic        tester_float_pin;
  // Resolved wire levels; floated strobes and data read as pulled up.
  logic [7:0]  data_w;
  logic [15:0] addr_w;
  logic        memory_request_n_w;
  logic        io_request_n_w;
  logic        read_w;
  logic        write_w;
  logic        m1_w;
  assign data_w  = cpu_data_oe ? cpu_data : (sys_data_oe ? sys_data : 8'hff);
  assign addr_w  = addr_oe ? addr : 16'hffff;
  assign memory_request_n_w  = ctrl_oe ? memory_request_n : 1'b1;
  assign io_request_n_w  = ctrl_oe ? io_request_n : 1'b1;
  assign read_w  = ctrl_oe ? read_n : 1'b1;
  assign write_w = ctrl_oe ? write_n : 1'b1;
  assign m1_w    = ctrl_oe ? first_cycle_n : 1'b1;
  modport cpu (
    output addr, addr_oe, cpu_data, cpu_data_oe, ctrl_oe, memory_request_n, io_request_n,
    output read_n, write_n, halt_n, first_cycle_n, refresh_strobe_n,
    input  data_w, wait_n, maskable_irq_n, nonmask_irq_n, bus_request_n, reset_n, tester_float_pin
  );
  modport sys (
    output sys_data, sys_data_oe, wait_n, maskable_irq_n, nonmask_irq_n, bus_request_n,
    output reset_n, tester_float_pin,
    input  data_w, addr_w, memory_request_n_w, io_request_n_w, read_w, write_w, m1_w, halt_n, refresh_strobe_n
  );
endinterface : cihr_bus_if
`default_nettype wire

//--- verilog/cihr_fall_det.sv
`default_nettype none
module cihr_fall_det (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level in, edge out
  input  wire logic level_i,
  output logic      fall_o
);
  logic prev_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= level_i;
    end
  end
  assign fall_o = prev_reg & ~level_i;
endmodule : cihr_fall_det
`default_nettype wire

//--- verilog/cihr_cpu_end.sv
// Function
// - Sample maskable request at instruction's last clock.
// - Refuse maskable request if gate clear or bus requested.
// - Acknowledge fetch inserts two automatic wait clocks.
// - Wait sampled on second automatic and later waits.
// - Acknowledge drives io request, not memory request.
// - Read strobe stays high during acknowledge.
// - Peripheral puts vector on data bus.
// - Third state outputs refresh address and strobe.
// - Push PC, then load PC from page and table.
// - Falling non-maskable input sets internal latch.
// - Non-maskable latch examined at instruction's last clock.
// - Non-maskable entry: discarded fetch, push, jump 0066H.
// - Halt output falls in fourth state of fetch.
// - Halted processor keeps issuing refresh fetches.
// - Halted: sample interrupts at fourth state, then exit.
// - Maskable exits halt only with gate set.
// - Power-down exit: interrupt or reset long enough.
// - Reset source holds reset low three clocks.
// - After reset: two-state dummy, then fetch 0000H.
// - Tester pin with bus request floats bus outputs except halt and refresh strobe.
// - Refresh address: page high, counter plus bit seven.
// - Wait sampled at second state and each wait.
`default_nettype none
module cihr_cpu_end
  import cihr_pkg::*;
#(
  parameter logic [7:0] HALT_OP = 8'h76
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Processor bus
  cihr_bus_if.cpu          bus,
  // Core controls
  input  wire logic        irq_enable_i,
  input  wire logic        irq_disable_i,
  input  wire logic [7:0]  page_i,
  input  wire logic        sp_load_i,
  input  wire logic [15:0] sp_i,
  // Core status
  output logic [7:0]       opcode_o,
  output logic             opcode_valid_o,
  output logic [7:0]       vector_o,
  output logic [15:0]      pc_o,
  output logic             irq_gate_o,
  output logic             halted_o
);
  typedef enum logic [3:0] {
    ST_RST, ST_DUM1, ST_DUM2, ST_T1, ST_T2, ST_TA1, ST_TA2, ST_TW, ST_T3, ST_T4, ST_M1, ST_M2, ST_M3
  } cihr_state_t;

  cihr_state_t st_reg, st_next;
  cihr_entry_t kind_reg, kind_next;
  logic [2:0]  mc_reg, mc_next;
  logic [15:0] pc_reg, pc_next, sp_reg, sp_next;
  logic [7:0]  r_reg, r_next, vec_reg, table_reg;
  logic        gate_reg, gate_next, halted_reg, halted_next, nmi_latch_reg, nmi_next;
  logic [15:0] addr_reg;
  logic [7:0]  dout_reg;
  logic        dout_oe_reg, drive_reg, memory_request_n_reg, io_request_n_reg, read_reg, write_reg;
  logic        halt_reg, m1_reg, refresh_strobe_n_reg, opv_reg;
  logic        nmi_fall;

  cihr_fall_det u_nmi_fall (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (bus.nonmask_irq_n),
    .fall_o  (nmi_fall)
  );

  wire entry_fetch = (kind_reg != CYC_NORMAL);
  wire is_ack      = (kind_reg == CYC_INT);
  wire wait_ok     = bus.wait_n;
  wire mc_last     = is_ack ? (mc_reg == MC_LAST_INT) : (mc_reg == MC_LAST_NMI);
  wire sample      = (st_reg == ST_T4) && !entry_fetch && bus.reset_n;
  wire int_ok      = !bus.maskable_irq_n && gate_reg && bus.bus_request_n;
  wire nmi_take    = sample && nmi_latch_reg;
  wire int_take    = sample && !nmi_latch_reg && int_ok;
  wire cap         = (st_next == ST_T3) && (st_reg != ST_T3);
  wire norm_cap    = cap && !entry_fetch && !halted_reg;
  wire table_cap   = (st_reg == ST_M2) && (st_next == ST_M3) && (mc_reg == MC_TABLE_LO);
  wire entry_done  = (st_reg == ST_M3) && mc_last;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_RST:         st_next = ST_DUM1;
      ST_DUM1:        st_next = ST_DUM2;
      ST_DUM2:        st_next = ST_T1;
      ST_T1:          st_next = ST_T2;
      ST_T2:          st_next = is_ack ? ST_TA1 : (wait_ok ? ST_T3 : ST_TW);
      ST_TA1:         st_next = ST_TA2;
      ST_TA2, ST_TW:  st_next = wait_ok ? ST_T3 : ST_TW;
      ST_T3:          st_next = ST_T4;
      ST_T4:          st_next = entry_fetch ? ST_M1 : ST_T1;
      ST_M1:          st_next = ST_M2;
      ST_M2:          st_next = wait_ok ? ST_M3 : ST_M2;
      ST_M3:          st_next = mc_last ? ST_T1 : ST_M1;
    endcase
    if (!bus.reset_n) begin
      st_next = ST_RST;
    end
  end

  // Entry bookkeeping; a held-low reset pin clears control state like rst_i.
  always_comb begin
    kind_next = kind_reg;
    mc_next   = mc_reg;
    if (nmi_take) begin
      kind_next = CYC_NMI;
    end else if (int_take) begin
      kind_next = CYC_INT;
    end else if (entry_done) begin
      kind_next = CYC_NORMAL;
    end
    if ((st_reg == ST_T4) && entry_fetch) begin
      mc_next = MC_FIRST_PUSH;
    end else if ((st_reg == ST_M3) && !mc_last) begin
      mc_next = 3'(mc_reg + 3'h1);
    end
    if (!bus.reset_n) begin
      kind_next = CYC_NORMAL;
      mc_next   = 3'h0;
    end
  end

  wire enter_push = (st_next == ST_M1) && (mc_next <= MC_LAST_PUSH);

  always_comb begin
    pc_next = pc_reg;
    if (!bus.reset_n) begin
      pc_next = RESET_PC;
    end else if (norm_cap) begin
      pc_next = 16'(pc_reg + 16'h0001);
    end else if (entry_done) begin
      pc_next = is_ack ? {page_i, table_reg} : NMI_PC;
    end
  end

  assign sp_next     = sp_load_i ? sp_i : (enter_push ? 16'(sp_reg - 16'h0001) : sp_reg);
  assign r_next      = (st_reg == ST_T4) ? {r_reg[7], 7'(r_reg[6:0] + 7'h01)} : r_reg;
  assign nmi_next    = nmi_fall | (nmi_latch_reg & ~nmi_take);
  assign gate_next   = bus.reset_n && !int_take && (irq_enable_i || (gate_reg && !irq_disable_i));
  assign halted_next = bus.reset_n && !nmi_take && !int_take &&
                       (halted_reg || (norm_cap && (bus.data_w == HALT_OP)));

  // Bus pins are decoded from the next state so that they leave flip-flops aligned with it.
  wire fetch_n = (st_next == ST_T1) || (st_next == ST_T2) || (st_next == ST_TA1) ||
                 (st_next == ST_TA2) || (st_next == ST_TW);
  wire ack_n   = (kind_next == CYC_INT);
  wire refresh_strobe_n_n  = (st_next == ST_T3) || (st_next == ST_T4);
  wire mem_n   = (st_next == ST_M1) || (st_next == ST_M2) || (st_next == ST_M3);
  wire wr_n    = mem_n && (mc_next <= MC_LAST_PUSH);
  wire strobe  = (st_next != ST_M3) && (st_next != ST_TA1) && (st_next != ST_TA2);
  wire [7:0]  tab_lo  = (mc_next == MC_TABLE_LO) ? vec_reg : 8'(vec_reg + 8'h01);
  wire [15:0] addr_n  = refresh_strobe_n_n ? {page_i, r_next} :
                        (mem_n ? (wr_n ? sp_next : {page_i, tab_lo}) : pc_next);
  wire memory_request_n_lo = (fetch_n && !ack_n && strobe) || (st_next == ST_T3) || (mem_n && strobe);
  wire read_lo = (fetch_n && !ack_n && strobe) || (mem_n && !wr_n && strobe);
  wire io_request_n_lo = fetch_n && ack_n && (st_next != ST_T1) && (st_next != ST_T2);
  wire halt_nx = !halted_next ? 1'b1 : ((st_next == ST_T4) ? 1'b0 : halt_reg);
  wire drive_n = !(bus.tester_float_pin && !bus.bus_request_n);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg        <= ST_RST;
      kind_reg      <= CYC_NORMAL;
      mc_reg        <= 3'h0;
      pc_reg        <= RESET_PC;
      sp_reg        <= 16'h0000;
      r_reg         <= REFRESH_INIT;
      gate_reg      <= 1'b0;
      halted_reg    <= 1'b0;
      nmi_latch_reg <= 1'b0;
    end else begin
      st_reg        <= st_next;
      kind_reg      <= kind_next;
      mc_reg        <= mc_next;
      pc_reg        <= pc_next;
      sp_reg        <= sp_next;
      r_reg         <= r_next;
      gate_reg      <= gate_next;
      halted_reg    <= halted_next;
      nmi_latch_reg <= nmi_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_reg   <= 8'h00;
      table_reg <= 8'h00;
      opcode_o  <= 8'h00;
      opv_reg   <= 1'b0;
    end else begin
      if (cap && is_ack) begin
        vec_reg <= bus.data_w;
      end
      if (table_cap) begin
        table_reg <= bus.data_w;
      end
      if (norm_cap) begin
        opcode_o <= bus.data_w;
      end
      opv_reg <= norm_cap;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_reg    <= RESET_PC;
      dout_reg    <= 8'h00;
      dout_oe_reg <= 1'b0;
      drive_reg   <= 1'b1;
      memory_request_n_reg    <= 1'b1;
      io_request_n_reg    <= 1'b1;
      read_reg    <= 1'b1;
      write_reg   <= 1'b1;
      halt_reg    <= 1'b1;
      m1_reg      <= 1'b1;
      refresh_strobe_n_reg    <= 1'b1;
    end else begin
      addr_reg    <= addr_n;
      dout_reg    <= (mc_next == MC_FIRST_PUSH) ? pc_next[15:8] : pc_next[7:0];
      dout_oe_reg <= wr_n && drive_n;
      drive_reg   <= drive_n;
      memory_request_n_reg    <= !memory_request_n_lo;
      io_request_n_reg    <= !io_request_n_lo;
      read_reg    <= !read_lo;
      write_reg   <= !(wr_n && (st_next == ST_M2));
      halt_reg    <= halt_nx;
      m1_reg      <= !fetch_n;
      refresh_strobe_n_reg    <= !refresh_strobe_n_n;
    end
  end

  assign bus.addr             = addr_reg;
  assign bus.addr_oe          = drive_reg;
  assign bus.cpu_data         = dout_reg;
  assign bus.cpu_data_oe      = dout_oe_reg;
  assign bus.ctrl_oe          = drive_reg;
  assign bus.memory_request_n = memory_request_n_reg;
  assign bus.io_request_n     = io_request_n_reg;
  assign bus.read_n           = read_reg;
  assign bus.write_n          = write_reg;
  assign bus.halt_n           = halt_reg;
  assign bus.first_cycle_n    = m1_reg;
  assign bus.refresh_strobe_n = refresh_strobe_n_reg;
  assign opcode_valid_o       = opv_reg;
  assign vector_o             = vec_reg;
  assign pc_o                 = pc_reg;
  assign irq_gate_o           = gate_reg;
  assign halted_o             = halted_reg;
endmodule : cihr_cpu_end
`default_nettype wire

//--- verilog/cihr_sys_end.sv
`default_nettype none
module cihr_sys_end
  import cihr_pkg::*;
#(
  parameter int MEM_AW   = 8,
  parameter int NMI_LOWS = NMI_LOW_CLKS
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Processor bus
  cihr_bus_if.sys                bus,
  // Requests
  input  wire logic              irq_req_i,
  input  wire logic              nmi_req_i,
  input  wire logic [7:0]        vector_i,
  input  wire logic [3:0]        wait_extra_i,
  input  wire logic              float_req_i,
  input  wire logic              bus_hold_i,
  input  wire logic              reset_req_i,
  // Memory preload
  input  wire logic              mem_we_i,
  input  wire logic [MEM_AW-1:0] mem_addr_i,
  input  wire logic [7:0]        mem_data_i,
  // Status
  output logic                   irq_pending_o,
  output logic                   ack_seen_o,
  output logic                   reset_busy_o
);
  if (MEM_AW < 1 || MEM_AW > ADDR_W) begin : g_bad_aw
    $error("MEM_AW out of range");
  end
  if (NMI_LOWS < 1 || NMI_LOWS > 15) begin : g_bad_nmi
    $error("NMI_LOWS out of range");
  end

  logic [7:0] mem [2**MEM_AW];
  logic [1:0] rst_cnt;
  logic [3:0] nmi_cnt, wcnt;
  logic       irq_reg, nmi_n_reg, rstn_reg, fl_reg, br_reg, ack_reg, strobe_prev, wait_reg;
  logic [7:0] dat_reg;
  logic       dat_oe_reg;

  wire ack_cyc  = !bus.io_request_n_w && !bus.m1_w;
  wire mem_rd   = !bus.memory_request_n_w && !bus.read_w;
  wire mem_wr   = !bus.memory_request_n_w && !bus.write_w;
  wire strobe   = ack_cyc || mem_rd || mem_wr;
  wire ack_edge = ack_cyc && !ack_reg;
  wire [3:0] wcnt_next = (strobe && !strobe_prev) ? wait_extra_i :
                         ((wcnt != 4'h0) ? 4'(wcnt - 4'h1) : 4'h0);
  wire [MEM_AW-1:0] maddr = bus.addr_w[MEM_AW-1:0];

  always_ff @(posedge clk_i) begin
    if (mem_wr) begin
      mem[maddr] <= bus.data_w;
    end else if (mem_we_i) begin
      mem[mem_addr_i] <= mem_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_cnt     <= 2'(RESET_MIN_CLKS);
      rstn_reg    <= 1'b0;
      irq_reg     <= 1'b0;
      nmi_cnt     <= 4'h0;
      nmi_n_reg   <= 1'b1;
      fl_reg      <= 1'b0;
      br_reg      <= 1'b1;
      ack_reg     <= 1'b0;
      strobe_prev <= 1'b0;
      wcnt        <= 4'h0;
      wait_reg    <= 1'b1;
      dat_reg     <= 8'h00;
      dat_oe_reg  <= 1'b0;
    end else begin
      if (reset_req_i) begin
        rst_cnt <= 2'(RESET_MIN_CLKS);
      end else if (rst_cnt != 2'h0) begin
        rst_cnt <= 2'(rst_cnt - 2'h1);
      end
      rstn_reg    <= !reset_req_i && (rst_cnt <= 2'h1);
      irq_reg     <= irq_req_i || (irq_reg && !ack_edge);
      nmi_cnt     <= nmi_req_i ? 4'(NMI_LOWS) : ((nmi_cnt != 4'h0) ? 4'(nmi_cnt - 4'h1) : 4'h0);
      nmi_n_reg   <= !(nmi_req_i || (nmi_cnt > 4'h1));
      fl_reg      <= float_req_i;
      br_reg      <= !bus_hold_i;
      ack_reg     <= ack_cyc;
      strobe_prev <= strobe;
      wcnt        <= wcnt_next;
      wait_reg    <= (wcnt_next == 4'h0);
      dat_reg     <= ack_cyc ? vector_i : mem[maddr];
      dat_oe_reg  <= ack_cyc || mem_rd;
    end
  end

  assign bus.sys_data         = dat_reg;
  assign bus.sys_data_oe      = dat_oe_reg;
  assign bus.wait_n           = wait_reg;
  assign bus.maskable_irq_n   = !irq_reg;
  assign bus.nonmask_irq_n    = nmi_n_reg;
  assign bus.bus_request_n    = br_reg;
  assign bus.reset_n          = rstn_reg;
  assign bus.tester_float_pin = fl_reg;
  assign irq_pending_o        = irq_reg;
  assign ack_seen_o           = ack_reg;
  assign reset_busy_o         = !rstn_reg;
endmodule : cihr_sys_end
`default_nettype wire

//--- testbench/cihr_bus_asserts.sv
`default_nettype none
module cihr_bus_asserts (
  // Clock, reset and page
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  page_i,
  // Processor side of the bus
  input wire logic [15:0] addr,
  input wire logic        addr_oe,
  input wire logic        cpu_data_oe,
  input wire logic        ctrl_oe,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        halt_n,
  input wire logic        first_cycle_n,
  input wire logic        refresh_strobe_n,
  // System side of the bus
  input wire logic        bus_request_n,
  input wire logic        reset_n,
  input wire logic        tester_float_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  // A bus reset aborts any cycle, so nothing is judged while it is low.
  default disable iff (rst_i || !reset_n);

  a_ack_io_only: assert property (!io_request_n |-> memory_request_n && read_n && !first_cycle_n)
    else $error("acknowledge strobes wrong");
  a_ack_two_waits: assert property ($fell(io_request_n) |=> !io_request_n)
    else $error("acknowledge shorter than two waits");
  a_ack_bounded: assert property ($fell(io_request_n) |-> ##[2:24] $rose(io_request_n))
    else $error("acknowledge did not end");
  a_refresh_memory_request_n: assert property ($fell(refresh_strobe_n) |-> !memory_request_n ##1 (memory_request_n && !refresh_strobe_n))
    else $error("refresh strobe sequence wrong");
  a_refresh_addr: assert property ($fell(refresh_strobe_n) |-> addr[15:8] == page_i && !addr[7])
    else $error("refresh address wrong");
  a_refresh_after: assert property ($rose(first_cycle_n) |-> !refresh_strobe_n && read_n)
    else $error("no refresh after fetch");
  a_push_write: assert property (!write_n |-> !memory_request_n && first_cycle_n && read_n)
    else $error("write strobe outside a push");
  a_halt_in_t4: assert property ($fell(halt_n) |-> !refresh_strobe_n && memory_request_n)
    else $error("halt output not in fourth state");
  a_halt_fetches: assert property ($fell(halt_n) |-> ##[1:40] $fell(first_cycle_n))
    else $error("no fetch while halted");
  a_float_bus: assert property (tester_float_pin && !bus_request_n |=> !addr_oe && !ctrl_oe && !cpu_data_oe)
    else $error("outputs not floated");
  a_reset_dummy: assert property ($rose(reset_n) |-> first_cycle_n[*2] ##[1:3] (!first_cycle_n && addr == 16'h0000))
    else $error("reset fetch wrong");

  c_ack: cover property ($fell(io_request_n));
  c_halt: cover property ($fell(halt_n));
  c_float: cover property (tester_float_pin && !bus_request_n);
  c_reset: cover property ($rose(reset_n));
endmodule : cihr_bus_asserts
`default_nettype wire

//--- testbench/cpu_interrupt_halt_reset_control_test.sv
`default_nettype none
`define CHECK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module cpu_interrupt_halt_reset_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cihr_pkg::*;
  logic        clk_i, rst_i, irq_enable_i, irq_disable_i, sp_load_i, irq_req_i, nmi_req_i;
  logic        float_req_i, bus_hold_i, reset_req_i, mem_we_i, irq_gate_o, halted_o, opcode_valid_o;
  logic        irq_pending_o, reset_busy_o, io_request_n_q, wr_q;
  logic [15:0] sp_i, pc_o;
  logic [7:0]  page_i, vector_i, mem_addr_i, mem_data_i, opcode_o, vector_o, seed, v;
  logic [7:0]  mem_img [256];
  logic [3:0]  wait_extra_i;
  int          miscompares, num_checks, n_ack, n_wr, n_rf, n_rlow, a0, w0;
  cihr_bus_if bus_i ();
  cihr_cpu_end cihr_cpu_end_i (.clk_i, .rst_i, .bus(bus_i), .irq_enable_i, .irq_disable_i, .page_i, .sp_load_i,
    .sp_i, .opcode_o, .opcode_valid_o, .vector_o, .pc_o, .irq_gate_o, .halted_o);
  cihr_sys_end cihr_sys_end_i (.clk_i, .rst_i, .bus(bus_i), .irq_req_i, .nmi_req_i, .vector_i, .wait_extra_i,
    .float_req_i, .bus_hold_i, .reset_req_i, .mem_we_i, .mem_addr_i, .mem_data_i, .irq_pending_o,
    .ack_seen_o(), .reset_busy_o);
  cihr_bus_asserts cihr_bus_asserts_i (.clk_i, .rst_i, .page_i, .addr(bus_i.addr), .addr_oe(bus_i.addr_oe),
    .cpu_data_oe(bus_i.cpu_data_oe), .ctrl_oe(bus_i.ctrl_oe), .memory_request_n(bus_i.memory_request_n),
    .io_request_n(bus_i.io_request_n), .read_n(bus_i.read_n), .write_n(bus_i.write_n), .halt_n(bus_i.halt_n),
    .first_cycle_n(bus_i.first_cycle_n), .refresh_strobe_n(bus_i.refresh_strobe_n),
    .bus_request_n(bus_i.bus_request_n), .reset_n(bus_i.reset_n), .tester_float_pin(bus_i.tester_float_pin));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Bus activity is counted on the falling edge, where every registered pin has settled.
  always @(negedge clk_i) begin
    n_ack += int'(!bus_i.io_request_n_w && io_request_n_q);
    n_wr += int'(!bus_i.write_w && wr_q);
    n_rf += int'(!bus_i.refresh_strobe_n);
    n_rlow += int'(!bus_i.reset_n && !rst_i);
    io_request_n_q <= bus_i.io_request_n_w;
    wr_q <= bus_i.write_w;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic [15:0] jump_pc(input logic [7:0] pg, input logic [7:0] vec);
    return {pg, mem_img[vec]};
  endfunction : jump_pc

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic wait_fetch(input logic [15:0] target, input string what);
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (!(bus_i.m1_w === 1'b0 && bus_i.memory_request_n_w === 1'b0 && bus_i.addr_w === target) && k < 600);
    `CHECK(what, target, bus_i.addr_w)
  endtask : wait_fetch

  task automatic wait_ack(input int base);
    int k;
    k = 0;
    while (n_ack == base && k < 600) begin
      @(negedge clk_i);
      k++;
    end
    `CHECK("acknowledge", 1'b1, n_ack > base)
  endtask : wait_ack

  task automatic do_reset();
    n_rlow = 0;
    @(posedge clk_i) reset_req_i <= 1'b1;
    @(posedge clk_i) reset_req_i <= 1'b0;
    wait_fetch(RESET_PC, "reset fetch");
    `CHECK("reset low clocks", 1'b1, n_rlow >= RESET_MIN_CLKS)
    @(posedge clk_i) sp_load_i <= 1'b1;
    @(posedge clk_i) sp_load_i <= 1'b0;
    $display("test reset done");
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {rst_i, irq_enable_i, irq_disable_i, sp_load_i, irq_req_i, nmi_req_i} = 6'h20;
    {float_req_i, bus_hold_i, reset_req_i, mem_we_i, io_request_n_q, wr_q} = 6'h03;
    {miscompares, num_checks, n_ack, n_wr, n_rf, n_rlow} = '0;
    seed = 8'h49;
    page_i = 8'h3c;
    sp_i = 16'h0080;
    vector_i = 8'h20;
    wait_extra_i = 4'h0;
    {mem_addr_i, mem_data_i} = 16'h0000;
    tick(4);
    rst_i <= 1'b0;
    // Halt opcode only at the non-maskable target, so no other fetch stops the core.
    for (int a = 0; a < 256; a++) begin
      seed = lfsr_next(seed);
      mem_img[a] = (a == 8'h66) ? 8'h76 : ((seed == 8'h76) ? 8'h00 : seed);
      @(posedge clk_i);
      mem_we_i <= 1'b1;
      mem_addr_i <= 8'(a);
      mem_data_i <= mem_img[a];
    end
    @(posedge clk_i) mem_we_i <= 1'b0;
    do_reset();
    // The page shows in refresh and vector table read addresses, so look inside the refresh strobe window.
    while (bus_i.refresh_strobe_n !== 1'b0) @(negedge clk_i);
    `CHECK("refresh page", page_i, bus_i.addr_w[15:8])
    for (int i = 0; i < 3; i++) begin
      seed = lfsr_next(seed);
      v = {3'b001, seed[4:1], 1'b0};
      a0 = n_ack;
      w0 = n_wr;
      @(posedge clk_i);
      vector_i <= v;
      wait_extra_i <= (i == 0) ? 4'h0 : ((i == 1) ? 4'hf : seed[7:4]);
      irq_enable_i <= 1'b1;
      irq_req_i <= 1'b1;
      @(posedge clk_i) {irq_enable_i, irq_req_i} <= 2'b00;
      wait_ack(a0);
      wait_fetch(jump_pc(page_i, v), "vector jump");
      `CHECK("vector", v, vector_o)
      `CHECK("gate", 1'b0, irq_gate_o)
      `CHECK("pushes", 2, n_wr - w0)
      $display("test maskable %0d done", i);
    end
    a0 = n_ack;
    @(posedge clk_i) irq_req_i <= 1'b1;
    @(posedge clk_i) irq_req_i <= 1'b0;
    tick(80);
    `CHECK("gate refuse", a0, n_ack)
    `CHECK("pending", 1'b1, irq_pending_o)
    @(posedge clk_i) {bus_hold_i, irq_enable_i} <= 2'b11;
    @(posedge clk_i) irq_enable_i <= 1'b0;
    tick(80);
    `CHECK("bus_request_n refuse", a0, n_ack)
    @(posedge clk_i) bus_hold_i <= 1'b0;
    wait_ack(a0);
    $display("test refusal done");
    // Let the accepted entry finish its pushes before the next count starts.
    wait_fetch(jump_pc(page_i, vector_i), "refusal jump");
    w0 = n_wr;
    a0 = n_ack;
    @(posedge clk_i) nmi_req_i <= 1'b1;
    // No waits from here, so the halt and refresh timing below is fixed.
    wait_extra_i <= 4'h0;
    @(posedge clk_i) nmi_req_i <= 1'b0;
    wait_fetch(NMI_PC, "nmi entry");
    `CHECK("nmi pushes", 2, n_wr - w0)
    `CHECK("nmi no ack", a0, n_ack)
    tick(12);
    `CHECK("halt out", 1'b0, bus_i.halt_n)
    w0 = n_rf;
    @(posedge clk_i) irq_req_i <= 1'b1;
    @(posedge clk_i) irq_req_i <= 1'b0;
    tick(60);
    `CHECK("halt refresh", 1'b1, n_rf > w0 + 8)
    `CHECK("halt kept", 1'b0, bus_i.halt_n)
    @(posedge clk_i) irq_enable_i <= 1'b1;
    @(posedge clk_i) irq_enable_i <= 1'b0;
    wait_ack(a0);
    `CHECK("halt left", 1'b1, bus_i.halt_n)
    $display("test halt done");
    @(posedge clk_i) {float_req_i, bus_hold_i} <= 2'b11;
    tick(4);
    @(negedge clk_i);
    `CHECK("float", 19'h7ffff, {bus_i.addr_w, bus_i.m1_w, bus_i.memory_request_n_w, bus_i.read_w})
    @(posedge clk_i) {float_req_i, bus_hold_i} <= 2'b00;
    tick(4);
    $display("test float done");
    do_reset();
    tally_and_finish();
  end

  initial begin
    #(20000 * 4);
    miscompares++;
    tally_and_finish();
  end
endmodule : cpu_interrupt_halt_reset_control_test
`default_nettype wire
